// ==== hdl/field_pair_mon.sv ====
// Field pair selection and changeover supervision with Wishbone registers
//
// Summary of operation
// - Old pair stays monitored during changeover
// - Any watched selection input change starts timer, except in fixed mode
// - New pair monitored only after expiry
// - Single high input k selects pair k
// - Single low input selects pairs six-ten
// - Inputs six-ten select second function pairs
// - Two functions: each half drives own group
// - Hundred pairs: columns from 1-5, rows 6-10
// - Banks: 6-10 pick bank, 1-5 pair
// - Forbidden group A transition forces outputs off
// - Deactivated group A target pair forces outputs off
// - Contour beyond tolerance forces outputs off
// - Invalid pattern at expiry raises fault
// - Changeover time never below forty ms
// - Occupied new field trips after sync+change+response
// - Fixed mode always monitors first pair
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module field_pair_mon #(
   parameter int TICK_CYC = `TICK_CYC_DEF
) (
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RESETN_I,
   // Selection pins, bit 0 is sel_in_1
   input  wire logic [9:0]  SEL_IN_I,
   // Measurement results for the monitored pairs
   input  wire logic [1:0]  FIELD_HIT_I,
   input  wire logic [11:0] CONTOUR_DEV_MM_I,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   // Safety and status outputs
   output logic             SAFETY_OUT_GROUP_A_O,
   output logic             SAFETY_OUT_GROUP_B_O,
   output logic [6:0]       MON_PAIR_A_O,
   output logic [6:0]       MON_PAIR_B_O,
   output logic             FAULT_O,
   output logic             IRQ_O
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [11:0] s1_ff, s2_ff, s3_ff, filt_ff;
   wire  [11:0] nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
   wire  [9:0]  sel      = filt_ff[9:0];
   wire  [1:0]  hit      = filt_ff[11:10];

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s1_ff   <= 12'h000;
         s2_ff   <= 12'h000;
         s3_ff   <= 12'h000;
         filt_ff <= 12'h000;
      end else begin
         s1_ff   <= {FIELD_HIT_I, SEL_IN_I};
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         filt_ff <= nxt_filt;
      end
   end

   // ****************************************
   // Millisecond tick
   // ****************************************
   logic [17:0] tick_cnt_ff;
   logic        tick_ff;
   wire         tick_wrap = (tick_cnt_ff == 18'(TICK_CYC - 1));

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tick_cnt_ff <= 18'h00000;
         tick_ff     <= 1'b0;
      end else begin
         tick_cnt_ff <= tick_wrap ? 18'h00000 : tick_cnt_ff + 18'h00001;
         tick_ff     <= tick_wrap;
      end
   end

   // ****************************************
   // Register file and bus decode
   // ****************************************
   fpc_pkg::mode_t mode_ff;
   logic        order_en_ff, contour_en_ff, fault_ff, irq_ff, ack_ff;
   logic [15:0] chg_ff, resp_ff;
   logic [1:0]  imask_ff, istat_ff;
   logic [31:0] rdat_ff, rmux, status_w;
   logic        out_ff [2];
   logic [6:0]  cur_ff [2];
   fpc_pkg::chst_t st_ff [2];

   wire        req      = WB_CYC_I & WB_STB_I & ~ack_ff;
   wire        wr       = WB_CYC_I & WB_STB_I & WB_WE_I & ack_ff;
   wire        rd       = req & ~WB_WE_I;
   wire        wr_ctrl  = wr & (WB_ADR_I == `REG_CTRL);
   wire        wr_chg   = wr & (WB_ADR_I == `REG_CHG_MS);
   wire        wr_resp  = wr & (WB_ADR_I == `REG_RESP_MS);
   wire        wr_mask  = wr & (WB_ADR_I == `REG_IRQ_MASK);
   wire        wr_tbl   = wr & (WB_ADR_I == `REG_TABLE) & WB_SEL_I[2] & WB_SEL_I[1] & WB_SEL_I[0];
   wire        rd_istat = rd & (WB_ADR_I == `REG_IRQ_STAT);
   wire [31:0] ctrl_w   = {26'h0000000, 1'b0, contour_en_ff, order_en_ff, mode_ff};
   wire [31:0] ctrl_new = fpc_pkg::bmerge(ctrl_w, WB_DAT_I, WB_SEL_I);
   wire [31:0] chg_new  = fpc_pkg::bmerge({16'h0000, chg_ff}, WB_DAT_I, WB_SEL_I);
   wire [31:0] resp_new = fpc_pkg::bmerge({16'h0000, resp_ff}, WB_DAT_I, WB_SEL_I);
   wire [31:0] mask_new = fpc_pkg::bmerge({30'h00000000, imask_ff}, WB_DAT_I, WB_SEL_I);
   wire        clr_req  = wr_ctrl & ctrl_new[`CTRL_CLEAR_BIT];

   always_comb begin
      status_w = 32'h00000000;
      status_w[`STAT_FAULT_BIT]  = fault_ff;
      status_w[`STAT_BUSY_A_BIT] = (st_ff[0] != fpc_pkg::ST_IDLE);
      status_w[`STAT_BUSY_B_BIT] = (st_ff[1] != fpc_pkg::ST_IDLE);
      status_w[`STAT_OUT_A_BIT]  = out_ff[0];
      status_w[`STAT_OUT_B_BIT]  = out_ff[1];
      status_w[`STAT_PAIR_A_LSB +: 7] = cur_ff[0];
      status_w[`STAT_PAIR_B_LSB +: 7] = cur_ff[1];
   end

   always_comb begin
      case (WB_ADR_I)
         `REG_CTRL:     rmux = ctrl_w;
         `REG_CHG_MS:   rmux = {16'h0000, chg_ff};
         `REG_RESP_MS:  rmux = {16'h0000, resp_ff};
         `REG_STATUS:   rmux = status_w;
         `REG_IRQ_STAT: rmux = {30'h00000000, istat_ff};
         `REG_IRQ_MASK: rmux = {30'h00000000, imask_ff};
         default:       rmux = 32'h00000000;
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ack_ff        <= 1'b0;
         rdat_ff       <= 32'h00000000;
         mode_ff       <= fpc_pkg::MODE_FIXED;
         order_en_ff   <= 1'b0;
         contour_en_ff <= 1'b0;
         chg_ff        <= `CHG_MS_RST;
         resp_ff       <= `RESP_MS_RST;
         imask_ff      <= 2'h0;
      end else begin
         ack_ff  <= req;
         rdat_ff <= rd ? rmux : 32'h00000000;
         if (wr_ctrl) begin
            mode_ff       <= fpc_pkg::mode_t'(ctrl_new[`CTRL_MODE_LSB +: 3]);
            order_en_ff   <= ctrl_new[`CTRL_ORDER_BIT];
            contour_en_ff <= ctrl_new[`CTRL_CONTOUR_BIT];
         end
         if (wr_chg)  chg_ff   <= chg_new[15:0];
         if (wr_resp) resp_ff  <= resp_new[15:0];
         if (wr_mask) imask_ff <= mask_new[1:0];
      end
   end

   // ****************************************
   // Pattern decode per operating mode
   // ****************************************
   wire [4:0]  dec_lo   = fpc_pkg::dec5(sel[4:0]);
   wire [4:0]  dec_hi   = fpc_pkg::dec5(sel[9:5]);
   wire        matrix   = (mode_ff == fpc_pkg::MODE_HUNDRED) || (mode_ff == fpc_pkg::MODE_BANKS);
   wire        two_fn   = (mode_ff == fpc_pkg::MODE_TWO);
   wire        fixed    = (mode_ff == fpc_pkg::MODE_FIXED);
   // Row (or bank) times ten plus column gives the flat pair number
   wire [6:0]  flat     = 7'({3'h0, dec_hi[3:0]} * 7'h0a + {3'h0, dec_lo[3:0]});
   fpc_pkg::pair_sel_t tgt [2];
   logic [9:0] watch [2];

   assign tgt[0].ok  = matrix ? (dec_lo[4] & dec_hi[4]) : dec_lo[4];
   assign tgt[0].idx = matrix ? flat : {3'h0, dec_lo[3:0]};
   assign watch[0]   = matrix ? sel : {5'h00, sel[4:0]};
   assign tgt[1].ok  = dec_hi[4];
   assign tgt[1].idx = {3'h0, dec_hi[3:0]};
   assign watch[1]   = {sel[9:5], 5'h00};

   // ****************************************
   // Order table
   // ****************************************
   fpc_pkg::pair_sel_t hold_ff [2];
   logic perm_rd, self_rd;

   order_mem #(
      .AW (14)
   ) u_order_mem (
      .clk_i     (MCLK_I),
      .rstn_i    (RESETN_I),
      .we_i      (wr_tbl),
      .waddr_i   (WB_DAT_I[`TBL_ADDR_LSB +: 14]),
      .wdata_i   (WB_DAT_I[`TBL_VAL_BIT]),
      .raddr_a_i ({cur_ff[0], hold_ff[0].idx}),
      .raddr_b_i ({hold_ff[0].idx, hold_ff[0].idx}),
      .rdata_a_o (perm_rd),
      .rdata_b_o (self_rd)
   );

   // ****************************************
   // Changeover channels
   // ****************************************
   // Timer covers the sync time plus the changeover time, never below the least time
   wire [15:0] chg_eff = (chg_ff < `MIN_CHG_MS) ? `MIN_CHG_MS : chg_ff;
   wire [15:0] load    = `SYNC_MS + chg_eff;
   logic [15:0] cnt_ff [2];
   logic [15:0] hcnt_ff [2];
   logic [9:0]  seen_ff [2];
   logic        have_ff [2];
   logic        chg_ev [2];
   logic        expire [2];
   logic        bad [2];
   logic        done [2];
   logic        trip [2];

   for (genvar c = 0; c < 2; c++) begin : g_ch
      wire active = (c == 0) || two_fn;
      wire ord_bad;

      if (c == 0) begin : g_ord
         // Permission of cur->tgt and the target's own entry (deactivated when clear)
         assign ord_bad = order_en_ff & ((have_ff[0] & ~perm_rd) | ~self_rd);
      end else begin : g_no_ord
         assign ord_bad = 1'b0;
      end

      assign chg_ev[c] = active && !fixed && (watch[c] != seen_ff[c]);
      assign expire[c] = (st_ff[c] == fpc_pkg::ST_WAIT) && tick_ff && (cnt_ff[c] == 16'h0001);
      assign bad[c]    = (st_ff[c] == fpc_pkg::ST_CHECK) && (!hold_ff[c].ok || ord_bad);
      assign done[c]   = (st_ff[c] == fpc_pkg::ST_CHECK) && !bad[c];
      assign trip[c]   = hit[c] && have_ff[c] && (hcnt_ff[c] >= resp_ff);

      always_ff @(posedge MCLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            st_ff[c]   <= fpc_pkg::ST_IDLE;
            cnt_ff[c]  <= 16'h0000;
            seen_ff[c] <= 10'h000;
            cur_ff[c]  <= 7'h00;
            have_ff[c] <= 1'b0;
            hold_ff[c] <= '0;
         end else begin
            case (st_ff[c])
               fpc_pkg::ST_IDLE: begin
                  if (fixed && c == 0) begin
                     cur_ff[c]  <= 7'h00;
                     have_ff[c] <= 1'b1;
                  end else if (chg_ev[c]) begin
                     seen_ff[c] <= watch[c];
                     cnt_ff[c]  <= load;
                     st_ff[c]   <= fpc_pkg::ST_WAIT;
                  end
               end
               fpc_pkg::ST_WAIT: begin
                  // Further edges do not restart the timer: it runs from the first change
                  if (chg_ev[c]) seen_ff[c] <= watch[c];
                  if (tick_ff) cnt_ff[c] <= cnt_ff[c] - 16'h0001;
                  if (expire[c]) begin
                     hold_ff[c] <= tgt[c];
                     st_ff[c]   <= fpc_pkg::ST_LOOK;
                  end
               end
               fpc_pkg::ST_LOOK: st_ff[c] <= fpc_pkg::ST_CHECK;
               fpc_pkg::ST_CHECK: begin
                  st_ff[c] <= fpc_pkg::ST_IDLE;
                  if (!bad[c]) begin
                     cur_ff[c]  <= hold_ff[c].idx;
                     have_ff[c] <= 1'b1;
                  end
               end
               default: st_ff[c] <= fpc_pkg::ST_IDLE;
            endcase
         end
      end

      always_ff @(posedge MCLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            hcnt_ff[c] <= 16'h0000;
         end else if (!(hit[c] && have_ff[c])) begin
            hcnt_ff[c] <= 16'h0000;
         end else if (tick_ff && hcnt_ff[c] != 16'hffff) begin
            hcnt_ff[c] <= hcnt_ff[c] + 16'h0001;
         end
      end
   end

   // ****************************************
   // Fault, outputs and interrupt
   // ****************************************
   wire contour_bad = contour_en_ff && (CONTOUR_DEV_MM_I > `CONTOUR_TOL_MM);
   wire fault_set   = bad[0] | bad[1] | contour_bad;
   wire nxt_fault   = fault_set | (fault_ff & ~clr_req);
   // Outside two-function mode group B follows group A
   wire nxt_out_a   = have_ff[0] & ~nxt_fault & ~trip[0];
   wire nxt_out_b   = two_fn ? (have_ff[1] & ~nxt_fault & ~trip[1]) : nxt_out_a;
   wire [1:0] ev    = {fault_set, done[0] | done[1]};
   wire [1:0] nxt_istat = ev | (istat_ff & ~{2{rd_istat}});

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fault_ff <= 1'b0;
         out_ff[0] <= 1'b0;
         out_ff[1] <= 1'b0;
         istat_ff <= 2'h0;
         irq_ff   <= 1'b0;
      end else begin
         fault_ff  <= nxt_fault;
         out_ff[0] <= nxt_out_a;
         out_ff[1] <= nxt_out_b;
         istat_ff  <= nxt_istat;
         irq_ff    <= |(nxt_istat & imask_ff);
      end
   end

   assign SAFETY_OUT_GROUP_A_O = out_ff[0];
   assign SAFETY_OUT_GROUP_B_O = out_ff[1];
   assign MON_PAIR_A_O         = cur_ff[0];
   assign MON_PAIR_B_O         = cur_ff[1];
   assign FAULT_O              = fault_ff;
   assign IRQ_O                = irq_ff;
   assign WB_DAT_O             = rdat_ff;
   assign WB_ACK_O             = ack_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence seq_expiry;
      st_ff[0] == fpc_pkg::ST_LOOK ##1 st_ff[0] == fpc_pkg::ST_CHECK;
   endsequence

   AST_FIXED_FIRST: assert property (
      fixed && st_ff[0] == fpc_pkg::ST_IDLE |=> cur_ff[0] == 7'h00 && have_ff[0])
      else $error("fixed mode does not monitor the first pair");
   AST_OLD_HELD: assert property (
      st_ff[0] == fpc_pkg::ST_WAIT |=> $stable(cur_ff[0]))
      else $error("monitored pair changed during changeover");
   AST_TIMER_START: assert property (
      st_ff[0] == fpc_pkg::ST_IDLE && chg_ev[0] |=> st_ff[0] == fpc_pkg::ST_WAIT
      && cnt_ff[0] == $past(load))
      else $error("changeover timer not started on input change");
   AST_NEW_AFTER: assert property (
      $changed(cur_ff[0]) && !fixed |-> $past(st_ff[0]) == fpc_pkg::ST_CHECK)
      else $error("new pair taken before timer expiry");
   AST_EXPIRY_SEQ: assert property (
      expire[0] |=> seq_expiry)
      else $error("expiry did not lead to the pattern check");
   AST_MIN_TIME: assert property (
      st_ff[0] == fpc_pkg::ST_WAIT |-> load >= (`SYNC_MS + `MIN_CHG_MS) && cnt_ff[0] <= load)
      else $error("changeover time below its least value");
   AST_BAD_PATTERN: assert property (
      st_ff[0] == fpc_pkg::ST_CHECK && !hold_ff[0].ok |=> fault_ff ##1 !out_ff[0])
      else $error("invalid pattern at expiry did not fault");
   AST_ORDER: assert property (
      st_ff[0] == fpc_pkg::ST_CHECK && order_en_ff && have_ff[0] && !perm_rd
      |=> fault_ff && $stable(cur_ff[0]))
      else $error("forbidden transition accepted");
   AST_DEACT: assert property (
      st_ff[0] == fpc_pkg::ST_CHECK && order_en_ff && !self_rd |=> !out_ff[0])
      else $error("deactivated pair accepted");
   AST_CONTOUR: assert property (
      contour_en_ff && CONTOUR_DEV_MM_I > `CONTOUR_TOL_MM |=> fault_ff && !out_ff[0])
      else $error("contour deviation did not switch off");
   AST_NO_PAIR_OFF: assert property (
      !have_ff[0] |=> !out_ff[0])
      else $error("output on without a selected pair");

endmodule // field_pair_mon

// ==== hdl/order_mem.sv ====
// Permitted changeover table: one write port, two registered read ports
`timescale 1ns/1ps
module order_mem #(
   parameter int AW = 14
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rstn_i,
   // Write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic          wdata_i,
   // Read ports
   input  wire logic [AW-1:0] raddr_a_i,
   input  wire logic [AW-1:0] raddr_b_i,
   output logic               rdata_a_o,
   output logic               rdata_b_o
);

   logic mem [2**AW];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_a_o <= 1'b0;
         rdata_b_o <= 1'b0;
      end else begin
         rdata_a_o <= mem[raddr_a_i];
         rdata_b_o <= mem[raddr_b_i];
      end
   end

endmodule // order_mem

// ==== inc/fpc_cfg.svh ====
// Register map, field positions and timing constants of the field pair changeover monitor
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL        8'h00
`define REG_CHG_MS      8'h04
`define REG_RESP_MS     8'h08
`define REG_STATUS      8'h0c
`define REG_IRQ_STAT    8'h10
`define REG_IRQ_MASK    8'h14
`define REG_TABLE       8'h18

// ****************************************
// Field positions
// ****************************************
`define CTRL_MODE_LSB   0
`define CTRL_ORDER_BIT  3
`define CTRL_CONTOUR_BIT 4
`define CTRL_CLEAR_BIT  5
`define STAT_FAULT_BIT  0
`define STAT_BUSY_A_BIT 1
`define STAT_BUSY_B_BIT 2
`define STAT_OUT_A_BIT  3
`define STAT_OUT_B_BIT  4
`define STAT_PAIR_A_LSB 8
`define STAT_PAIR_B_LSB 16
`define TBL_ADDR_LSB    0
`define TBL_VAL_BIT     16
`define IRQ_DONE_BIT    0
`define IRQ_FAULT_BIT   1

// ****************************************
// Reset values
// ****************************************
`define CHG_MS_RST      16'h0000
`define RESP_MS_RST     16'h0000

// ****************************************
// Timing (40 ms sync, 40 ms least changeover, 200 mm tolerance)
// ****************************************
`define SYNC_MS         16'h0028
`define MIN_CHG_MS      16'h0028
`define CONTOUR_TOL_MM  12'h0c8
`define MS_NS           1000000
`define CLK_NS          4
`define TICK_CYC_DEF    ((`MS_NS) / (`CLK_NS))

`endif

// ==== inc/fpc_pkg.sv ====
// Types and shared functions of the field pair changeover monitor
package fpc_pkg;

   typedef enum logic [2:0] {
      MODE_FIXED   = 3'h0,
      MODE_TEN     = 3'h1,
      MODE_TWO     = 3'h2,
      MODE_HUNDRED = 3'h3,
      MODE_BANKS   = 3'h4
   } mode_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_LOOK  = 4'b0100,
      ST_CHECK = 4'b1000
   } chst_t;

   typedef struct packed {
      logic       ok;
      logic [6:0] idx;
   } pair_sel_t;

   // Five pins to a ten pattern code: [4] valid, [3:0] zero based pair
   function automatic logic [4:0] dec5(input logic [4:0] f);
      case (f)
         5'h01:   dec5 = 5'h10;
         5'h02:   dec5 = 5'h11;
         5'h04:   dec5 = 5'h12;
         5'h08:   dec5 = 5'h13;
         5'h10:   dec5 = 5'h14;
         5'h0f:   dec5 = 5'h15;
         5'h17:   dec5 = 5'h16;
         5'h1b:   dec5 = 5'h17;
         5'h1d:   dec5 = 5'h18;
         5'h1e:   dec5 = 5'h19;
         default: dec5 = 5'h00;
      endcase
   endfunction

   // Byte lane merge of a bus write
   function automatic logic [31:0] bmerge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      bmerge = (old_w & ~m) | (new_w & m);
   endfunction

endpackage

// ==== verif/field_pair_changeover_monitor_test.sv ====
// Self-checking bench of the field pair changeover monitor
`timescale 1ns/1ps
`include "fpc_cfg.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin num_errors++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module field_pair_changeover_monitor_test;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [9:0]  want = 10'h3ff;
   logic [9:0]  sel;
   logic [1:0]  hit = 2'b00;
   logic [11:0] dev = 12'h000;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  bsel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        out_a;
   logic        out_b;
   logic [6:0]  pair_a;
   logic [6:0]  pair_b;
   logic        fault;
   logic        irq;
   logic [31:0] q;
   int          num_errors = 0;
   int          checked = 0;
   logic [4:0]  pats [10] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10,
                              5'h0f, 5'h17, 5'h1b, 5'h1d, 5'h1e};

   always #2 mclk = ~mclk;

   sel_ctrl_model u_sel_ctrl_model (.clk_i(mclk), .want_i(want), .sel_o(sel));

   field_pair_mon #(.TICK_CYC(10)) u_field_pair_mon (
      .MCLK_I(mclk), .RESETN_I(resetn), .SEL_IN_I(sel), .FIELD_HIT_I(hit),
      .CONTOUR_DEV_MM_I(dev), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(bsel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .SAFETY_OUT_GROUP_A_O(out_a), .SAFETY_OUT_GROUP_B_O(out_b),
      .MON_PAIR_A_O(pair_a), .MON_PAIR_B_O(pair_b), .FAULT_O(fault), .IRQ_O(irq));

   task automatic conclude();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Classic single cycle; ack is sampled at the edge, so no race with the slave
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      bsel <= 4'hf;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) begin
         num_errors++;
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic perm(input logic [6:0] f, input logic [6:0] t, input logic p);
      wb(1'b1, `REG_TABLE, {15'h0000, p, 2'b00, f, t});
   endtask

   // Timer is 80 ticks of 10 cycles less one tick, so 600 cycles is still inside it
   task automatic change(input logic [9:0] p, input logic [6:0] old_p, input logic chk);
      @(posedge mclk);
      want <= p;
      repeat (600) @(posedge mclk);
      if (chk) `CHK("held pair", old_p, pair_a)
      repeat (300) @(posedge mclk);
   endtask

   task automatic fixed_mode();
      repeat (5) @(posedge mclk);
      `CHK("out_a in reset", 1'b0, out_a)
      resetn <= 1'b1;
      repeat (10) @(posedge mclk);
      `CHK("fixed pair", 7'h00, pair_a)
      `CHK("fixed out_a", 1'b1, out_a)
      wb(1'b0, `REG_CHG_MS, 32'h0);
      `CHK("chg reset", 32'h0, q)
      wb(1'b0, 8'hfc, 32'h0);
      `CHK("unmapped", 32'h0, q)
      change(10'h002, 7'h00, 1'b1);
      `CHK("fixed pair", 7'h00, pair_a)
   endtask

   task automatic ten_pairs();
      wb(1'b1, `REG_CTRL, 32'h1);
      wb(1'b1, `REG_CHG_MS, 32'h0);
      wb(1'b1, `REG_IRQ_MASK, 32'h1);
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      for (int k = 0; k < 10; k++) begin
         change({5'h00, pats[k]}, 7'(k - 1), k > 0);
         `CHK("pair_a", 7'(k), pair_a)
      end
      `CHK("out_a", 1'b1, out_a)
      `CHK("irq", 1'b1, irq)
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      `CHK("irq stat", 32'h1, q)
      repeat (3) @(posedge mclk);
      `CHK("irq cleared", 1'b0, irq)
   endtask

   task automatic bad_pattern();
      change(10'h003, 7'h09, 1'b1);
      `CHK("fault", 1'b1, fault)
      `CHK("out_a", 1'b0, out_a)
      `CHK("pair kept", 7'h09, pair_a)
      wb(1'b1, `REG_CTRL, 32'h21);
      repeat (2) @(posedge mclk);
      `CHK("fault cleared", 1'b0, fault)
   endtask

   task automatic order_check();
      perm(7'd9, 7'd2, 1'b1);
      perm(7'd2, 7'd2, 1'b1);
      perm(7'd2, 7'd4, 1'b0);
      perm(7'd4, 7'd4, 1'b1);
      perm(7'd2, 7'd0, 1'b1);
      perm(7'd4, 7'd0, 1'b1);
      perm(7'd0, 7'd0, 1'b0);
      wb(1'b1, `REG_CTRL, 32'h09);
      change(10'h004, 7'h09, 1'b1);
      `CHK("permitted", 1'b0, fault)
      `CHK("pair_a", 7'h02, pair_a)
      change(10'h010, 7'h02, 1'b1);
      `CHK("forbidden", 1'b1, fault)
      `CHK("out_a", 1'b0, out_a)
      wb(1'b1, `REG_CTRL, 32'h29);
      change(10'h001, 7'h00, 1'b0);
      `CHK("deactivated", 1'b1, fault)
      wb(1'b1, `REG_CTRL, 32'h21);
   endtask

   task automatic two_functions();
      int n;
      wb(1'b1, `REG_CTRL, 32'h2);
      change({5'h17, 5'h08}, 7'h00, 1'b0);
      `CHK("pair_a", 7'h03, pair_a)
      `CHK("pair_b", 7'h06, pair_b)
      change({5'h1e, 5'h08}, 7'h03, 1'b1);
      `CHK("pair_b", 7'h09, pair_b)
      `CHK("pair_a", 7'h03, pair_a)
      wb(1'b1, `REG_RESP_MS, 32'h3);
      hit <= 2'b10;
      repeat (15) @(posedge mclk);
      `CHK("out_b early", 1'b1, out_b)
      n = 0;
      while (out_b !== 1'b0 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      `CHK("out_b tripped", 1'b0, out_b)
      `CHK("out_a kept", 1'b1, out_a)
      hit <= 2'b00;
   endtask

   task automatic matrix();
      wb(1'b1, `REG_CTRL, 32'h3);
      change({5'h04, 5'h0f}, 7'h00, 1'b0);
      `CHK("hundred pair", 7'd25, pair_a)
      wb(1'b1, `REG_CTRL, 32'h4);
      change({5'h1e, 5'h01}, 7'd25, 1'b1);
      `CHK("bank pair", 7'd90, pair_a)
   endtask

   task automatic contour();
      wb(1'b1, `REG_CTRL, 32'h14);
      dev <= 12'd200;
      repeat (5) @(posedge mclk);
      `CHK("within tolerance", 1'b0, fault)
      dev <= 12'd201;
      repeat (3) @(posedge mclk);
      `CHK("beyond tolerance", 1'b1, fault)
      `CHK("out_a", 1'b0, out_a)
   endtask

   initial begin
      fixed_mode();
      ten_pairs();
      bad_pattern();
      order_check();
      two_functions();
      matrix();
      contour();
      conclude();
   end
endmodule // field_pair_changeover_monitor_test

// ==== verif/sel_ctrl_model.sv ====
// Controller model that drives the selection pins of the monitor
`timescale 1ns/1ps
module sel_ctrl_model (
   // Clock
   input  wire logic       clk_i,
   // Pattern requested by the bench
   input  wire logic [9:0] want_i,
   // Selection pins
   output logic [9:0]      sel_o
);
   // One clean step per request, then the pattern stays put; bounce is not modelled
   always @(posedge clk_i) begin
      sel_o <= want_i;
   end
endmodule // sel_ctrl_model
